// ---- inc/crbd_pkg.sv ----
// crbd_pkg: constants and carrier types for the register/memory and branch decoder
package crbd_pkg;

  // opcode high nibble selects the addressing row
  localparam logic [3:0] NIB_IMM = 4'hA;
  localparam logic [3:0] NIB_DIR = 4'hB;
  localparam logic [3:0] NIB_EXT = 4'hC;
  localparam logic [3:0] NIB_IX = 4'hF;
  localparam logic [3:0] NIB_IX1 = 4'hE;
  localparam logic [3:0] NIB_IX2 = 4'hD;
  localparam logic [3:0] NIB_BRANCH = 4'h2;
  localparam logic [7:0] OPC_REL_CALL = 8'hAD;

  // base cycle counts per addressing mode for arithmetic rows
  localparam logic [2:0] CYC_IMM = 3'h2;
  localparam logic [2:0] CYC_DIR = 3'h3;
  localparam logic [2:0] CYC_EXT = 3'h4;
  localparam logic [2:0] CYC_IX = 3'h3;
  localparam logic [2:0] CYC_IX1 = 3'h4;
  localparam logic [2:0] CYC_IX2 = 3'h5;
  localparam logic [2:0] CYC_STORE_EXTRA = 3'h1;
  localparam logic [2:0] CYC_JUMP_LESS = 3'h1;
  localparam logic [2:0] CYC_ABS_CALL_EXTRA = 3'h2;
  localparam logic [2:0] CYC_BRANCH = 3'h3;
  localparam logic [2:0] CYC_REL_CALL = 3'h6;

  // instruction lengths in bytes
  localparam logic [1:0] LEN_IMM = 2'h2;
  localparam logic [1:0] LEN_DIR = 2'h2;
  localparam logic [1:0] LEN_EXT = 2'h3;
  localparam logic [1:0] LEN_IX = 2'h1;
  localparam logic [1:0] LEN_IX1 = 2'h2;
  localparam logic [1:0] LEN_IX2 = 2'h3;
  localparam logic [1:0] LEN_BRANCH = 2'h2;
  localparam logic [1:0] LEN_REL_CALL = 2'h2;

  // stack lives in the top 64 bytes of page zero
  localparam logic [9:0] STACK_PAGE = 10'h003;
  localparam logic [5:0] SP_RESET = 6'h3F;
  localparam logic [2:0] PUSH_LO_CNT = 3'h5;
  localparam logic [2:0] PUSH_HI_CNT = 3'h4;

  typedef enum logic [4:0] {
    crbd_sub_op, crbd_compare_accumulator_op, crbd_subtract_with_borrow_op,
    crbd_compare_index_op, crbd_and_op, crbd_bit_test_op, crbd_load_acc_op,
    crbd_store_accumulator_op, crbd_exclusive_or_op, crbd_add_carry_op, crbd_or_op,
    crbd_add_op, crbd_jump_op, crbd_absolute_call_op, crbd_load_index_op,
    crbd_store_index_op, crbd_branch_op, crbd_relative_call_op, crbd_none_op
  } crbd_op_e;

  typedef enum logic [2:0] {
    crbd_imm_mode, crbd_dir_mode, crbd_ext_mode, crbd_ix_mode,
    crbd_ix1_mode, crbd_ix2_mode, crbd_rel_mode, crbd_none_mode
  } crbd_mode_e;

  typedef struct packed {
    crbd_op_e op;
    crbd_mode_e mode;
    logic [1:0] length;
    logic [2:0] cycles;
    logic illegal;
  } crbd_dec_s;

  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } crbd_flags_s;

endpackage

// ---- hdl/crbd_pin_sync.sv ----
// crbd_pin_sync: three-stage synchroniser with agreement filter for a pin
`timescale 1ns/1ps
module crbd_pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // pin and filtered level
  input wire logic pin_in,
  output logic level_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s1_q <= RESET_LEVEL;
      s2_q <= RESET_LEVEL;
      s3_q <= RESET_LEVEL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once the two later stages agree
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      level_out <= RESET_LEVEL;
    end else if (s2_q == s3_q) begin
      level_out <= s3_q;
    end
  end

endmodule

// ---- hdl/crbd_core.sv ----
// crbd_core: register/memory and relative-branch decode and execution timing
//
// How it works
// - add-with-carry decoded on A9..F9, adds carry
// - subtract-with-borrow rows with documented bytes, cycles
// - compare accumulator sets flags, keeps accumulator
// - compare index sets flags, arithmetic timing
// - bit test ANDs, flags only
// - exclusive-or writes result to accumulator
// - branches two bytes, three cycles; always/never
// - higher and lower-or-same on carry, zero
// - carry clear and carry set branches
// - half-carry clear and set branches
// - interrupt mask clear and set branches
// - branch on sampled interrupt pin level
// - relative call two bytes, six cycles
// - stack wraps within 64 page-zero bytes
// - half carry from bit 3 into 4
// - masked interrupt request held pending
`timescale 1ns/1ps
module crbd_core (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // fetched instruction from the memory bus
  input wire logic opcode_valid_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] operand_in,
  input wire logic [15:0] pc_in,
  // interrupt pin and mask control
  input wire logic irq_pin_in,
  input wire logic irq_ack_in,
  input wire logic mask_set_in,
  input wire logic mask_clear_in,
  // handshake and decode result
  output logic ready_out,
  output logic done_out,
  output crbd_pkg::crbd_dec_s dec_out,
  output logic branch_taken_out,
  output logic [15:0] target_out,
  // programmer-visible state
  output logic [7:0] acc_out,
  output logic [7:0] idx_out,
  output crbd_pkg::crbd_flags_s flags_out,
  output logic [5:0] sp_out,
  // stack write port
  output logic stack_we_out,
  output logic [15:0] stack_addr_out,
  output logic [7:0] stack_data_out,
  // interrupt request state
  output logic irq_pending_out,
  output logic irq_service_out
);

  typedef enum logic [0:0] {crbd_idle_st, crbd_exec_st} crbd_state_e;

  crbd_state_e state_q;
  logic [2:0] cnt_q;
  logic [15:0] ret_q;
  logic irq_level;
  logic irq_level_q;
  logic accept;
  logic cond_base;
  logic taken;
  logic [8:0] sum;
  logic [7:0] reg_v;
  logic [7:0] res;
  logic wr_acc;
  logic wr_idx;
  logic upd_nz;
  logic upd_c;
  logic upd_h;
  logic [15:0] next_pc;
  crbd_pkg::crbd_dec_s dec;

  function automatic crbd_pkg::crbd_dec_s decode(input logic [7:0] opc);
    crbd_pkg::crbd_dec_s d;
    logic [2:0] base;
    d = '0;
    d.op = crbd_pkg::crbd_none_op;
    d.mode = crbd_pkg::crbd_none_mode;
    d.illegal = 1'b1;
    base = 3'h0;
    case (opc[7:4])
      crbd_pkg::NIB_IMM: begin
        d.mode = crbd_pkg::crbd_imm_mode;
        d.length = crbd_pkg::LEN_IMM;
        base = crbd_pkg::CYC_IMM;
      end
      crbd_pkg::NIB_DIR: begin
        d.mode = crbd_pkg::crbd_dir_mode;
        d.length = crbd_pkg::LEN_DIR;
        base = crbd_pkg::CYC_DIR;
      end
      crbd_pkg::NIB_EXT: begin
        d.mode = crbd_pkg::crbd_ext_mode;
        d.length = crbd_pkg::LEN_EXT;
        base = crbd_pkg::CYC_EXT;
      end
      crbd_pkg::NIB_IX: begin
        d.mode = crbd_pkg::crbd_ix_mode;
        d.length = crbd_pkg::LEN_IX;
        base = crbd_pkg::CYC_IX;
      end
      crbd_pkg::NIB_IX1: begin
        d.mode = crbd_pkg::crbd_ix1_mode;
        d.length = crbd_pkg::LEN_IX1;
        base = crbd_pkg::CYC_IX1;
      end
      crbd_pkg::NIB_IX2: begin
        d.mode = crbd_pkg::crbd_ix2_mode;
        d.length = crbd_pkg::LEN_IX2;
        base = crbd_pkg::CYC_IX2;
      end
      crbd_pkg::NIB_BRANCH: begin
        d.mode = crbd_pkg::crbd_rel_mode;
        d.length = crbd_pkg::LEN_BRANCH;
        base = crbd_pkg::CYC_BRANCH;
      end
      default: begin
        d.mode = crbd_pkg::crbd_none_mode;
      end
    endcase
    if (d.mode == crbd_pkg::crbd_rel_mode) begin
      d.op = crbd_pkg::crbd_branch_op;
      d.cycles = base;
      d.illegal = 1'b0;
    end else if (opc == crbd_pkg::OPC_REL_CALL) begin
      d.op = crbd_pkg::crbd_relative_call_op;
      d.mode = crbd_pkg::crbd_rel_mode;
      d.length = crbd_pkg::LEN_REL_CALL;
      d.cycles = crbd_pkg::CYC_REL_CALL;
      d.illegal = 1'b0;
    end else if (d.mode != crbd_pkg::crbd_none_mode) begin
      // low nibble order matches the enum order for the sixteen columns
      d.op = crbd_pkg::crbd_op_e'({1'b0, opc[3:0]});
      d.illegal = 1'b0;
      d.cycles = base;
      case (d.op)
        crbd_pkg::crbd_store_accumulator_op, crbd_pkg::crbd_store_index_op: begin
          d.cycles = base + crbd_pkg::CYC_STORE_EXTRA;
        end
        crbd_pkg::crbd_jump_op: begin
          d.cycles = base - crbd_pkg::CYC_JUMP_LESS;
        end
        crbd_pkg::crbd_absolute_call_op: begin
          d.cycles = base + crbd_pkg::CYC_ABS_CALL_EXTRA;
        end
        default: begin
          d.cycles = base;
        end
      endcase
      if (d.mode == crbd_pkg::crbd_imm_mode &&
          (d.op == crbd_pkg::crbd_store_accumulator_op ||
           d.op == crbd_pkg::crbd_store_index_op ||
           d.op == crbd_pkg::crbd_jump_op)) begin
        d.illegal = 1'b1;
        d.op = crbd_pkg::crbd_none_op;
        d.cycles = 3'h0;
      end
    end
    if (d.illegal) begin
      d.length = 2'h0;
    end
    return d;
  endfunction

  crbd_pin_sync #(
    .RESET_LEVEL(1'b1)
  ) u_irq_sync (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .pin_in(irq_pin_in),
    .level_out(irq_level)
  );

  assign dec = decode(opcode_in);
  assign accept = opcode_valid_in && ready_out;
  assign next_pc = pc_in + {14'h0000, crbd_pkg::LEN_BRANCH};

  // branch condition: pairs of opcodes share a test, bit 0 inverts it
  always_comb begin
    case (opcode_in[3:1])
      3'h0: cond_base = 1'b1;
      3'h1: cond_base = ~(flags_out.c | flags_out.z);
      3'h2: cond_base = ~flags_out.c;
      3'h3: cond_base = ~flags_out.z;
      3'h4: cond_base = ~flags_out.h;
      3'h5: cond_base = ~flags_out.n;
      3'h6: cond_base = ~flags_out.i;
      3'h7: cond_base = ~irq_level;
      default: cond_base = 1'b0;
    endcase
    taken = cond_base ^ opcode_in[0];
  end

  // arithmetic and logic on the selected register
  always_comb begin
    wr_acc = 1'b0;
    wr_idx = 1'b0;
    upd_nz = 1'b1;
    upd_c = 1'b0;
    upd_h = 1'b0;
    case (dec.op)
      crbd_pkg::crbd_compare_index_op, crbd_pkg::crbd_load_index_op,
      crbd_pkg::crbd_store_index_op: reg_v = idx_out;
      default: reg_v = acc_out;
    endcase
    case (dec.op)
      crbd_pkg::crbd_add_op, crbd_pkg::crbd_add_carry_op: begin
        sum = {1'b0, reg_v} + {1'b0, operand_in} +
              {8'h00, (dec.op == crbd_pkg::crbd_add_carry_op) & flags_out.c};
        wr_acc = 1'b1;
        upd_c = 1'b1;
        upd_h = 1'b1;
      end
      crbd_pkg::crbd_sub_op, crbd_pkg::crbd_subtract_with_borrow_op: begin
        sum = {1'b0, reg_v} - {1'b0, operand_in} -
              {8'h00, (dec.op == crbd_pkg::crbd_subtract_with_borrow_op) & flags_out.c};
        wr_acc = 1'b1;
        upd_c = 1'b1;
      end
      crbd_pkg::crbd_compare_accumulator_op, crbd_pkg::crbd_compare_index_op: begin
        sum = {1'b0, reg_v} - {1'b0, operand_in};
        upd_c = 1'b1;
      end
      crbd_pkg::crbd_and_op, crbd_pkg::crbd_bit_test_op: begin
        sum = {1'b0, reg_v & operand_in};
        wr_acc = (dec.op == crbd_pkg::crbd_and_op);
      end
      crbd_pkg::crbd_or_op: begin
        sum = {1'b0, reg_v | operand_in};
        wr_acc = 1'b1;
      end
      crbd_pkg::crbd_exclusive_or_op: begin
        sum = {1'b0, reg_v ^ operand_in};
        wr_acc = 1'b1;
      end
      crbd_pkg::crbd_load_acc_op: begin
        sum = {1'b0, operand_in};
        wr_acc = 1'b1;
      end
      crbd_pkg::crbd_load_index_op: begin
        sum = {1'b0, operand_in};
        wr_idx = 1'b1;
      end
      crbd_pkg::crbd_store_accumulator_op, crbd_pkg::crbd_store_index_op: begin
        sum = {1'b0, reg_v};
      end
      default: begin
        sum = {1'b0, reg_v};
        upd_nz = 1'b0;
      end
    endcase
    res = sum[7:0];
  end

  // sequencing: one accept, then the documented cycle count
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= crbd_idle_st;
      cnt_q <= 3'h0;
      ready_out <= 1'b1;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state_q)
        crbd_idle_st: begin
          if (accept && dec.illegal) begin
            done_out <= 1'b1;
          end else if (accept) begin
            state_q <= crbd_exec_st;
            cnt_q <= dec.cycles - 3'h1;
            ready_out <= 1'b0;
          end
        end
        crbd_exec_st: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h1) begin
            state_q <= crbd_idle_st;
            ready_out <= 1'b1;
            done_out <= 1'b1;
          end
        end
        default: begin
          state_q <= crbd_idle_st;
          ready_out <= 1'b1;
        end
      endcase
    end
  end

  // decode and branch result, held until the next accept
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      dec_out <= '0;
      branch_taken_out <= 1'b0;
      target_out <= 16'h0000;
      ret_q <= 16'h0000;
    end else if (accept) begin
      dec_out <= dec;
      branch_taken_out <= (dec.op == crbd_pkg::crbd_branch_op) && taken;
      target_out <= next_pc + {{8{operand_in[7]}}, operand_in};
      ret_q <= next_pc;
    end
  end

  // accumulator and index register
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      acc_out <= 8'h00;
      idx_out <= 8'h00;
    end else if (accept && !dec.illegal) begin
      if (wr_acc) begin
        acc_out <= res;
      end
      if (wr_idx) begin
        idx_out <= res;
      end
    end
  end

  // condition flags; the mask bit is steered from outside as well
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      flags_out <= '0;
      flags_out.i <= 1'b1;
    end else begin
      if (accept && !dec.illegal && upd_nz) begin
        flags_out.n <= res[7];
        flags_out.z <= (res == 8'h00);
      end
      if (accept && !dec.illegal && upd_c) begin
        flags_out.c <= sum[8];
      end
      if (accept && !dec.illegal && upd_h) begin
        flags_out.h <= reg_v[4] ^ operand_in[4] ^ res[4];
      end
      if (mask_set_in) begin
        flags_out.i <= 1'b1;
      end else if (mask_clear_in) begin
        flags_out.i <= 1'b0;
      end
    end
  end

  // relative call pushes the return address, low byte first
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sp_out <= crbd_pkg::SP_RESET;
      stack_we_out <= 1'b0;
      stack_addr_out <= 16'h0000;
      stack_data_out <= 8'h00;
    end else begin
      stack_we_out <= 1'b0;
      if (state_q == crbd_exec_st && dec_out.op == crbd_pkg::crbd_relative_call_op &&
          (cnt_q == crbd_pkg::PUSH_LO_CNT || cnt_q == crbd_pkg::PUSH_HI_CNT)) begin
        stack_we_out <= 1'b1;
        stack_addr_out <= {crbd_pkg::STACK_PAGE, sp_out};
        stack_data_out <= (cnt_q == crbd_pkg::PUSH_LO_CNT) ? ret_q[7:0] : ret_q[15:8];
        // six-bit pointer wraps inside the page when it decrements past zero
        sp_out <= sp_out - 6'h01;
      end
    end
  end

  // falling edge on the request pin is latched; set wins over ack
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_level_q <= 1'b1;
      irq_pending_out <= 1'b0;
      irq_service_out <= 1'b0;
    end else begin
      irq_level_q <= irq_level;
      if (irq_level_q && !irq_level) begin
        irq_pending_out <= 1'b1;
      end else if (irq_ack_in) begin
        irq_pending_out <= 1'b0;
      end
      // service only offered at an instruction boundary with the mask clear
      irq_service_out <= irq_pending_out && !flags_out.i && ready_out;
    end
  end

endmodule

// ---- verif/crbd_core_asserts.sv ----
// crbd_core_asserts: concurrent checks on the decoder core ports
`timescale 1ns/1ps
module crbd_core_asserts (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // instruction port
  input wire logic opcode_valid_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] operand_in,
  input wire logic [15:0] pc_in,
  input wire logic ready_out,
  input wire logic done_out,
  input wire crbd_pkg::crbd_dec_s dec_out,
  input wire logic branch_taken_out,
  input wire logic [15:0] target_out,
  // programmer state
  input wire logic [7:0] acc_out,
  input wire logic [7:0] idx_out,
  input wire crbd_pkg::crbd_flags_s flags_out,
  input wire logic [5:0] sp_out,
  input wire logic stack_we_out,
  input wire logic [15:0] stack_addr_out,
  input wire logic [7:0] stack_data_out,
  input wire logic irq_service_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  logic acc_ok;
  logic rm;
  logic [3:0] hi;
  logic [3:0] lo;
  assign acc_ok = opcode_valid_in && ready_out;
  assign hi = opcode_in[7:4];
  assign lo = opcode_in[3:0];
  assign rm = hi inside {4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
  // {length, cycles} of one addressing row
  function automatic logic [4:0] row_timing(input logic [3:0] n);
    case (n)
      4'hA: row_timing = 5'h12;
      4'hB: row_timing = 5'h13;
      4'hC: row_timing = 5'h1C;
      4'hF: row_timing = 5'h0B;
      4'hE: row_timing = 5'h14;
      default: row_timing = 5'h1D;
    endcase
  endfunction
  function automatic logic cond(input logic [3:0] k, input crbd_pkg::crbd_flags_s f);
    logic [13:0] v;
    v = {f.i, !f.i, f.n, !f.n, f.h, !f.h, f.z, !f.z, f.c, !f.c, f.c | f.z, !(f.c | f.z),
      1'b0, 1'b1};
    cond = v[k];
  endfunction
  sequence push_s(logic [15:0] a, logic [7:0] d);
    stack_we_out && stack_addr_out == a && stack_data_out == d;
  endsequence
  sequence end_after_s;
    !done_out ##1 done_out;
  endsequence
  row_timing_a: assert property (acc_ok && rm && !(lo inside {4'h7, 4'hC, 4'hD, 4'hF})
    |=> {dec_out.length, dec_out.cycles} == row_timing($past(hi))) else $error("row timing");
  branch_timing_a: assert property (acc_ok && hi == 4'h2 |=> dec_out.length == 2'h2 &&
    dec_out.cycles == 3'h3 && target_out == $past(pc_in) + 16'h0002 +
    {{8{$past(operand_in[7])}}, $past(operand_in)} ##1 end_after_s) else $error("branch timing");
  branch_cond_a: assert property (acc_ok && hi == 4'h2 && lo < 4'hE
    |=> branch_taken_out == cond($past(lo), $past(flags_out))) else $error("branch condition");
  rel_call_a: assert property (acc_ok && opcode_in == 8'hAD |=> dec_out.cycles == 3'h6 &&
    dec_out.length == 2'h2 ##4 end_after_s) else $error("relative call timing");
  stack_push_a: assert property (acc_ok && opcode_in == 8'hAD |-> ##2
    push_s({10'h003, $past(sp_out, 2)}, 8'($past(pc_in, 2) + 16'h0002)) ##1
    push_s({10'h003, 6'($past(sp_out, 3) - 6'h01)}, 8'(($past(pc_in, 3) + 16'h0002) >> 8)))
    else $error("stack push");
  imm_illegal_a: assert property (acc_ok && opcode_in inside {8'hA7, 8'hAF, 8'hAC}
    |=> dec_out.illegal && ready_out && done_out && $stable(acc_out) ##1 !done_out)
    else $error("illegal slot");
  flag_only_a: assert property (acc_ok && rm && lo inside {4'h1, 4'h3, 4'h5}
    |=> $stable(acc_out) && $stable(idx_out)) else $error("compare changed register");
  adc_sum_a: assert property (acc_ok && rm && lo == 4'h9 |=> acc_out == 8'($past(acc_out) +
    $past(operand_in) + $past(flags_out.c)) && flags_out.h == (5'($past(acc_out[3:0])) +
    5'($past(operand_in[3:0])) + 5'($past(flags_out.c)) > 5'h0F)) else $error("add carry");
  xor_result_a: assert property (acc_ok && rm && lo == 4'h8
    |=> acc_out == ($past(acc_out) ^ $past(operand_in))) else $error("exclusive or");
  masked_irq_a: assert property (irq_service_out |-> !$past(flags_out.i)) else $error("masked irq");
endmodule
bind crbd_core crbd_core_asserts u_chk (.ref_clk_in, .reset_in, .opcode_valid_in, .opcode_in,
  .operand_in, .pc_in, .ready_out, .done_out, .dec_out, .branch_taken_out, .target_out, .acc_out,
  .idx_out, .flags_out, .sp_out, .stack_we_out, .stack_addr_out, .stack_data_out, .irq_service_out);

// ---- verif/crbd_mem_model.sv ----
// crbd_mem_model: memory bus side, presents fetched instructions and keeps the stack bytes
`timescale 1ns/1ps
module crbd_mem_model (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // instruction to present
  input wire logic req_in,
  input wire logic [7:0] opc_in,
  input wire logic [7:0] opr_in,
  input wire logic [15:0] pc_in,
  // core side
  input wire logic ready_in,
  input wire logic stack_we_in,
  input wire logic [15:0] stack_addr_in,
  input wire logic [7:0] stack_data_in,
  output logic valid_out,
  output logic [7:0] opcode_out,
  output logic [7:0] operand_out,
  output logic [15:0] pc_out,
  output logic taken_out
);
  logic [7:0] mem_q [64];
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      valid_out <= 1'b0;
      taken_out <= 1'b0;
      opcode_out <= 8'h00;
      operand_out <= 8'h00;
      pc_out <= 16'h0000;
    end else begin
      taken_out <= valid_out && ready_in;
      if (valid_out && ready_in) begin
        // released lines flip so a stale value can never look valid
        valid_out <= 1'b0;
        opcode_out <= ~opcode_out;
        operand_out <= ~operand_out;
        pc_out <= ~pc_out;
      end else if (req_in && !valid_out) begin
        valid_out <= 1'b1;
        opcode_out <= opc_in;
        operand_out <= opr_in;
        pc_out <= pc_in;
      end
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (stack_we_in) begin
      mem_q[stack_addr_in[5:0]] <= stack_data_in;
    end
  end
endmodule

// ---- verif/testbench.sv ----
// testbench: directed scenarios for the register/memory and branch decoder
`timescale 1ns/1ps
module testbench;
  logic ref_clk_in, reset_in, req, valid, taken, irq_pin, irq_ack, mask_set, mask_clear;
  logic ready, done, br, stack_we, pending, service;
  logic [7:0] opc, opr, opcode, operand, acc, idx, stack_data;
  logic [15:0] pcv, pc, target, stack_addr;
  logic [5:0] sp;
  crbd_pkg::crbd_dec_s dec;
  crbd_pkg::crbd_flags_s flags;
  int fail_count, n_checks, n;
  // {expected taken, opcode} with c=1 z=0 n=1 h=1 i=1
  localparam logic [8:0] BR1 [12] = '{9'h120, 9'h021, 9'h022, 9'h123, 9'h024, 9'h125, 9'h028,
    9'h129, 9'h02C, 9'h12D, 9'h02A, 9'h12B};
  localparam logic [3:0] ROW [6] = '{4'hA, 4'hB, 4'hC, 4'hF, 4'hE, 4'hD};
  localparam int CYC [6] = '{2, 3, 4, 3, 4, 5};
  localparam int LEN [6] = '{2, 2, 3, 1, 2, 3};
  crbd_core uut (.ref_clk_in, .reset_in, .opcode_valid_in(valid), .opcode_in(opcode),
    .operand_in(operand), .pc_in(pc), .irq_pin_in(irq_pin), .irq_ack_in(irq_ack),
    .mask_set_in(mask_set), .mask_clear_in(mask_clear), .ready_out(ready), .done_out(done),
    .dec_out(dec), .branch_taken_out(br), .target_out(target), .acc_out(acc), .idx_out(idx),
    .flags_out(flags), .sp_out(sp), .stack_we_out(stack_we), .stack_addr_out(stack_addr),
    .stack_data_out(stack_data), .irq_pending_out(pending), .irq_service_out(service));
  crbd_mem_model mem (.ref_clk_in, .reset_in, .req_in(req), .opc_in(opc), .opr_in(opr),
    .pc_in(pcv), .ready_in(ready), .stack_we_in(stack_we), .stack_addr_in(stack_addr),
    .stack_data_in(stack_data), .valid_out(valid), .opcode_out(opcode), .operand_out(operand),
    .pc_out(pc), .taken_out(taken));
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // n ends as the cycle count from the accepting edge to done
  task automatic exec(input logic [7:0] o, input logic [7:0] d, input logic [15:0] p);
    int k;
    @(posedge ref_clk_in);
    req <= 1'b1; opc <= o; opr <= d; pcv <= p;
    @(posedge ref_clk_in);
    req <= 1'b0;
    n = 0;
    for (k = 0; k < 40; k++) begin
      @(posedge ref_clk_in);
      #1;
      if (taken === 1'b1) n = 1;
      else if (n > 0) n++;
      if (done === 1'b1) break;
    end
    if (k == 40) begin
      chk(1'b0, 1'b1);
      give_verdict();
    end
  endtask
  task automatic mask(input logic clr);
    @(posedge ref_clk_in);
    mask_clear <= clr; mask_set <= !clr;
    @(posedge ref_clk_in);
    mask_clear <= 1'b0; mask_set <= 1'b0;
  endtask
  task automatic s_arith;
    exec(8'hA9, 8'h0F, 16'h0100); chk(acc, 16'h000F);
    exec(8'hB9, 8'h01, 16'h0102); chk(flags.h, 1'b1); chk(acc, 16'h0010);
    exec(8'hA8, 8'hFF, 16'h0104); chk(acc, 16'h00EF);
    exec(8'hA1, 8'hEF, 16'h0106); chk(acc, 16'h00EF); chk(flags.z, 1'b1);
    exec(8'hE5, 8'h01, 16'h0108); chk(acc, 16'h00EF); chk(flags.z, 1'b0);
    exec(8'hA3, 8'h01, 16'h010A); chk(idx, 16'h0000); chk(flags.c, 1'b1);
    for (int i = 0; i < 6; i++) begin
      exec({ROW[i], 4'h2}, 8'h00, 16'h0110);
      chk(16'(n), 16'(CYC[i]));
      chk(dec.length, 16'(LEN[i]));
      chk(dec.mode, 16'(i));
    end
  endtask
  task automatic s_branch;
    exec(8'hA6, 8'h00, 16'h0200);
    exec(8'hA1, 8'h01, 16'h0202);
    foreach (BR1[i]) begin
      exec(BR1[i][7:0], 8'hFE, 16'h1000);
      chk(br, BR1[i][8]);
      chk(16'(n), 16'h0003);
      chk(target, 16'h1000);
    end
    exec(8'hA1, 8'h00, 16'h0204);
    exec(8'h22, 8'h7F, 16'h10FE); chk(br, 1'b0); chk(target, 16'h117F);
    exec(8'h23, 8'h00, 16'h1000); chk(br, 1'b1);
    exec(8'h24, 8'h00, 16'h1000); chk(br, 1'b1);
    exec(8'h25, 8'h00, 16'h1000); chk(br, 1'b0);
    mask(1'b1);
    exec(8'h2C, 8'h00, 16'h1000); chk(br, 1'b1);
    exec(8'h2D, 8'h00, 16'h1000); chk(br, 1'b0);
    mask(1'b0);
    irq_pin <= 1'b0;
    repeat (8) @(posedge ref_clk_in);
    exec(8'h2E, 8'h00, 16'h1000); chk(br, 1'b1);
    exec(8'h2F, 8'h00, 16'h1000); chk(br, 1'b0);
    chk(pending, 1'b1); chk(service, 1'b0);
    @(posedge ref_clk_in) irq_pin <= 1'b1;
    repeat (8) @(posedge ref_clk_in);
    exec(8'h2F, 8'h00, 16'h1000); chk(br, 1'b1);
    chk(pending, 1'b1);
    mask(1'b1);
    repeat (3) @(posedge ref_clk_in);
    #1 chk(service, 1'b1);
    @(posedge ref_clk_in);
    irq_ack <= 1'b1;
    @(posedge ref_clk_in);
    irq_ack <= 1'b0;
    #1 chk(pending, 1'b0);
  endtask
  task automatic s_call;
    exec(8'hAD, 8'h10, 16'h2345); chk(16'(n), 16'h0006); chk(target, 16'h2357);
    chk(mem.mem_q[6'h3F], 16'h0047); chk(mem.mem_q[6'h3E], 16'h0023); chk(sp, 16'h003D);
    // 32 calls of two bytes fill the 64-byte stack exactly once round
    repeat (31) exec(8'hAD, 8'h00, 16'h3000);
    chk(sp, 16'h003F);
  endtask
  task automatic s_illegal;
    exec(8'hA6, 8'h5A, 16'h0300);
    foreach (BR1[i]) if (i < 3) begin
      exec(i == 0 ? 8'hA7 : (i == 1 ? 8'hAF : 8'hAC), 8'h11, 16'h0302);
      chk(dec.illegal, 1'b1); chk(dec.cycles, 16'h0000); chk(acc, 16'h005A);
    end
  endtask
  initial begin
    reset_in = 1'b1; req = 1'b0; opc = 8'h00; opr = 8'h00; pcv = 16'h0000;
    irq_pin = 1'b1; irq_ack = 1'b0; mask_set = 1'b0; mask_clear = 1'b0;
    fail_count = 0; n_checks = 0;
    repeat (6) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    #1 chk(sp, 16'h003F); chk(flags.i, 1'b1); chk(acc, 16'h0000);
    s_arith();
    s_branch();
    s_call();
    s_illegal();
    give_verdict();
  end
endmodule
